// >>> global_lock_reset_freqmon_regs.v
/*
 * APB register bank for the global lock, block soft resets, frequency
 * monitor window timing and output monitor selection, with the window
 * timers on the crystal clock domain expressed as ticks sampled on pclk.
 * Assumes an APB master, crystal clock ticks synchronous to pclk, and a
 * presetn that is asserted only at power cycling.
 */
// Overview of operation
// - Lock bit set blocks all OTP programming
// - Lock clears only by power-cycle reset
// - Bit 11 holds spread engine in reset
// - Spread reset also resets fast dividers
// - Bit 10 holds crystal switching in reset
// - Bit 4 holds output monitor in reset
// - Bit 3 holds short-term monitor in reset
// - Bit 2 holds accuracy monitor in reset
// - Bits 1:0 hold crystal loss monitors
// - Slow window counts completed fast windows
// - Fast window counts crystal cycles, minimum two
// - Each monitor picks slow or fast window
// - Shutdown bit disables all output monitoring
// - Bits 11:0 enable true output monitoring
// - Bits 23:12 enable complementary output monitoring
// - Unselected true output status forced zero
// - Unselected complementary output status forced zero
`timescale 1ns/10ps
`include "global_regs_consts.vh"

module global_lock_reset_freqmon_regs
(
   // APB slave.
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // OTP programming request and grant.
   input  wire        otp_prog_req,
   output reg         otp_prog_grant,
   output reg         otp_locked,
   // Block resets.
   output reg         spread_engine_reset,
   output reg         high_perf_divider_a_reset,
   output reg         high_perf_divider_b_reset,
   output reg         crystal_switch_reset,
   output reg         output_monitor_reset,
   output reg         short_term_monitor_reset,
   output reg         crystal_accuracy_reset,
   output reg  [1:0]  crystal_loss_monitor_reset,
   // Window timing, crystal clock tick and per-monitor window choice.
   input  wire        xtal_tick,
   input  wire [11:0] monitor_use_slow,
   output reg         fast_window_end,
   output reg         slow_window_end,
   output reg  [11:0] monitor_window_end,
   // Output frequency status from the monitors, and gated status.
   input  wire [11:0] raw_out_sts,
   input  wire [11:0] raw_outb_sts,
   output reg  [11:0] out_sts,
   output reg  [11:0] outb_sts,
   output reg  [11:0] out_mon_enable,
   output reg  [11:0] outb_mon_enable
);

   reg  [31:0] lock_q;
   reg  [31:0] resets_q;
   reg  [31:0] window_q;
   reg  [31:0] select_q;
   reg  [15:0] fast_cnt_q;
   reg  [7:0]  slow_cnt_q;
   reg  [31:0] rdata_d;
   reg         hit_d;
   wire        wr_en;
   wire        rd_en;
   wire        mon_off;
   wire [15:0] fast_len;
   wire [7:0]  slow_len;
   wire        fast_wrap;
   wire        slow_wrap;

   assign wr_en    = psel & penable & pwrite;
   assign rd_en    = psel & penable & ~pwrite;
   assign mon_off  = select_q[`OFF_BIT];
   assign fast_len = window_q[`FAST_HI:`FAST_LO];
   assign slow_len = window_q[`SLOW_HI:`SLOW_LO];
   // Lengths below the minimum are treated as the minimum so the timer runs.
   assign fast_wrap = xtal_tick &
      (fast_cnt_q >= ((fast_len < `FAST_MIN) ? (`FAST_MIN - 16'h0001)
                                               : (fast_len - 16'h0001)));
   assign slow_wrap = fast_wrap & (slow_cnt_q + 8'h01 >= slow_len);

   ////////////////////////////////////////////////////////////////////////
   // Address decode and read mux.

   always @*
   begin
      rdata_d = `RESET_ZERO;
      hit_d   = 1'b1;
      case (paddr)
         `OFS_LOCK:   rdata_d = lock_q;
         `OFS_RESETS: rdata_d = resets_q;
         `OFS_WINDOW: rdata_d = window_q;
         `OFS_SELECT: rdata_d = select_q;
         default:     hit_d   = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait state, answer in the second access cycle.

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit_d;
         prdata  <= (rd_en & ~pready & hit_d) ? rdata_d : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers; writes land on the edge where pready is sampled high.

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lock_q   <= `RESET_ZERO;
         resets_q <= `RESET_ZERO;
         window_q <= `RESET_ZERO;
         select_q <= `RESET_ZERO;
      end
      else if (wr_en & pready)
      begin
         case (paddr)
            // Write one sets; a zero leaves the lock as it is.
            `OFS_LOCK:
               lock_q[`LOCK_BIT] <= lock_q[`LOCK_BIT] | pwdata[`LOCK_BIT];
            `OFS_RESETS: resets_q <= pwdata & `RESETS_MASK;
            `OFS_WINDOW: window_q <= pwdata & `WINDOW_MASK;
            `OFS_SELECT: select_q <= pwdata & `SELECT_MASK;
            default:     lock_q   <= lock_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // OTP lock and block reset outputs.

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         otp_prog_grant             <= 1'b0;
         otp_locked                 <= 1'b0;
         spread_engine_reset        <= 1'b0;
         high_perf_divider_a_reset  <= 1'b0;
         high_perf_divider_b_reset  <= 1'b0;
         crystal_switch_reset       <= 1'b0;
         output_monitor_reset       <= 1'b0;
         short_term_monitor_reset   <= 1'b0;
         crystal_accuracy_reset     <= 1'b0;
         crystal_loss_monitor_reset <= 2'h0;
      end
      else
      begin
         otp_prog_grant             <= otp_prog_req & ~lock_q[`LOCK_BIT];
         otp_locked                 <= lock_q[`LOCK_BIT];
         spread_engine_reset        <= resets_q[`RST_SPREAD_BIT];
         high_perf_divider_a_reset  <= resets_q[`RST_SPREAD_BIT];
         high_perf_divider_b_reset  <= resets_q[`RST_SPREAD_BIT];
         crystal_switch_reset       <= resets_q[`RST_XSWITCH_BIT];
         output_monitor_reset       <= resets_q[`RST_OUTMON_BIT];
         short_term_monitor_reset   <= resets_q[`RST_SHORT_BIT];
         crystal_accuracy_reset     <= resets_q[`RST_ACC_BIT];
         crystal_loss_monitor_reset <= resets_q[`RST_LOSS_HI:`RST_LOSS_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Window timers; held in reset with the output monitor.

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_cnt_q      <= 16'h0000;
         slow_cnt_q      <= 8'h00;
         fast_window_end <= 1'b0;
         slow_window_end <= 1'b0;
      end
      else if (resets_q[`RST_OUTMON_BIT] | mon_off)
      begin
         fast_cnt_q      <= 16'h0000;
         slow_cnt_q      <= 8'h00;
         fast_window_end <= 1'b0;
         slow_window_end <= 1'b0;
      end
      else
      begin
         fast_window_end <= fast_wrap;
         slow_window_end <= slow_wrap;
         if (xtal_tick)
            fast_cnt_q <= fast_wrap ? 16'h0000 : fast_cnt_q + 16'h0001;
         if (fast_wrap)
            slow_cnt_q <= slow_wrap ? 8'h00 : slow_cnt_q + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-output window choice, enables and status gating.

   genvar n;
   generate
      for (n = 0; n < `NUM_OUTPUTS; n = n + 1)
      begin : g_out
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               monitor_window_end[n] <= 1'b0;
               out_mon_enable[n]     <= 1'b0;
               outb_mon_enable[n]    <= 1'b0;
               out_sts[n]            <= 1'b0;
               outb_sts[n]           <= 1'b0;
            end
            else
            begin
               monitor_window_end[n] <= (resets_q[`RST_OUTMON_BIT] | mon_off) ? 1'b0 :
                  (monitor_use_slow[n] ? slow_wrap : fast_wrap);
               out_mon_enable[n]  <= ~mon_off & select_q[`OUT_LO + n];
               outb_mon_enable[n] <= ~mon_off & select_q[`OUTB_LO + n];
               out_sts[n]  <= ~mon_off & select_q[`OUT_LO + n] & raw_out_sts[n];
               outb_sts[n] <= ~mon_off & select_q[`OUTB_LO + n] & raw_outb_sts[n];
            end
         end
      end
   endgenerate

endmodule

// >>> global_regs_consts.vh
/*
 * Register offsets, field positions and reset values for the global lock,
 * soft reset, monitor window and output monitor select registers.
 * Assumes inclusion by bare name from the register bank module.
 */
`ifndef GLOBAL_REGS_CONSTS_VH
`define GLOBAL_REGS_CONSTS_VH

`define OFS_LOCK          12'h000
`define OFS_RESETS        12'h004
`define OFS_WINDOW        12'h008
`define OFS_SELECT        12'h00C

`define LOCK_BIT          0
`define RST_SPREAD_BIT    11
`define RST_XSWITCH_BIT   10
`define RST_OUTMON_BIT    4
`define RST_SHORT_BIT     3
`define RST_ACC_BIT       2
`define RST_LOSS_HI       1
`define RST_LOSS_LO       0

`define RESETS_MASK       32'h00000C1F
`define WINDOW_MASK       32'h00FFFFFF
`define SELECT_MASK       32'h01FFFFFF

`define SLOW_HI           23
`define SLOW_LO           16
`define FAST_HI           15
`define FAST_LO           0
`define OFF_BIT           24
`define OUTB_HI           23
`define OUTB_LO           12
`define OUT_HI            11
`define OUT_LO            0
`define NUM_OUTPUTS       12

`define RESET_ZERO        32'h00000000
`define FAST_MIN          16'h0002

`endif

// >>> regs_asserts.sv
/* Concurrent checks on the global register bank ports.
   Assumes it is bound into global_lock_reset_freqmon_regs. */
`timescale 1ns/10ps
module regs_asserts
(
   // Clock and reset.
   input wire        pclk, presetn,
   // Lock and block resets.
   input wire        otp_locked, otp_prog_grant, spread_engine_reset,
   input wire        high_perf_divider_a_reset, high_perf_divider_b_reset, output_monitor_reset,
   // Windows and gated status.
   input wire        fast_window_end, slow_window_end,
   input wire [11:0] monitor_window_end, raw_out_sts, raw_outb_sts,
   input wire [11:0] out_sts, outb_sts, out_mon_enable, outb_mon_enable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_lock_sticky; otp_locked |=> otp_locked; endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");
   property p_no_grant; otp_locked |=> !otp_prog_grant; endproperty
   a_no_grant: assert property (p_no_grant) else $error("grant while locked");
   property p_div_rst; high_perf_divider_a_reset == spread_engine_reset
      && high_perf_divider_b_reset == spread_engine_reset; endproperty
   a_div_rst: assert property (p_div_rst) else $error("divider reset differs");
   property p_gate; out_sts == ($past(raw_out_sts) & out_mon_enable)
      && outb_sts == ($past(raw_outb_sts) & outb_mon_enable); endproperty
   a_gate: assert property (p_gate) else $error("status not gated");
   property p_quiet; output_monitor_reset [*3] |-> !fast_window_end && !slow_window_end; endproperty
   a_quiet: assert property (p_quiet) else $error("window end in reset");
   property p_fast; fast_window_end |=> !fast_window_end; endproperty
   a_fast: assert property (p_fast) else $error("fast window too short");
   property p_slow; slow_window_end |-> fast_window_end; endproperty
   a_slow: assert property (p_slow) else $error("slow end off fast end");
   property p_win; monitor_window_end != 12'h000 |-> fast_window_end; endproperty
   a_win: assert property (p_win) else $error("monitor end off fast end");
endmodule
bind global_lock_reset_freqmon_regs regs_asserts u_chk (.*);

// >>> testbench.sv
/* Self-checking bench for the global register bank over APB.
   Assumes the design, its header and the checker are compiled first. */
`timescale 1ns/10ps
`include "global_regs_consts.vh"
module testbench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic        otp_prog_req = 0, xtal_tick = 0;
   logic [11:0] paddr = 0, monitor_use_slow = 0, raw_out_sts = 0, raw_outb_sts = 0, x, y;
   logic [31:0] pwdata = 0, rd, v, m;
   wire  [31:0] prdata;
   wire         pready, pslverr, otp_prog_grant, otp_locked, spread_engine_reset;
   wire         high_perf_divider_a_reset, high_perf_divider_b_reset, crystal_switch_reset;
   wire         output_monitor_reset, short_term_monitor_reset, crystal_accuracy_reset;
   wire         fast_window_end, slow_window_end;
   wire  [1:0]  crystal_loss_monitor_reset;
   wire  [11:0] monitor_window_end, out_sts, outb_sts, out_mon_enable, outb_mon_enable;
   int          fails = 0, checks_done = 0, cyc = 0, n [4], model [4] = '{0, 0, 0, 0};
   logic [31:0] mask [4] = '{32'h1, `RESETS_MASK, `WINDOW_MASK, `SELECT_MASK};
   global_lock_reset_freqmon_regs DUT (.*);
   always #20 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fails++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d);
      if (a == `OFS_LOCK) model[0] |= d & 32'h1;
      else model[a[3:2]] = d & mask[a[3:2]];
   endtask
   task rdc(input logic [11:0] a);
      apb(0, a, 0);
      chk(rd, model[a[3:2]]);
   endtask
   initial
   begin
      v = $urandom(32'h84b6);
      repeat (5) @(posedge pclk);
      presetn <= 1;
      for (int i = 0; i < 4; i++) rdc(i * 4);
      apb(0, 12'h010, 0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1, 12'h010, 32'hFFFFFFFF);
      chk(err, 1);
      for (int i = 0; i < 4; i++) rdc(i * 4);
      $display("test reset values done");
      otp_prog_req <= 1;
      repeat (3) @(negedge pclk);
      chk(otp_prog_grant, 1);
      wr(`OFS_LOCK, 32'hFFFFFFFF);
      rdc(`OFS_LOCK);
      @(negedge pclk);
      chk({otp_locked, otp_prog_grant}, 2'b10);
      wr(`OFS_LOCK, 0);
      rdc(`OFS_LOCK);
      $display("test lock done");
      // No divider is in use here, so the spread reset may be set freely.
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 32'hFFFFFFFF : $urandom;
         wr(`OFS_RESETS, v);
         rdc(`OFS_RESETS);
         m = model[1];
         chk({spread_engine_reset, high_perf_divider_a_reset, high_perf_divider_b_reset,
              crystal_switch_reset, output_monitor_reset, short_term_monitor_reset,
              crystal_accuracy_reset, crystal_loss_monitor_reset},
             {m[11], m[11], m[11], m[10], m[4:0]});
      end
      wr(`OFS_RESETS, 0);
      $display("test soft resets done");
      xtal_tick <= 1;
      monitor_use_slow <= 12'h001;
      for (int j = 0; j < 2; j++)
      begin
         wr(`OFS_WINDOW, j ? 32'h00000001 : 32'h00020003);
         rdc(`OFS_WINDOW);
         n = '{0, 0, 0, 0};
         repeat (12) @(posedge pclk);
         repeat (60)
         begin
            @(negedge pclk);
            n[0] += fast_window_end;
            n[1] += slow_window_end;
            n[2] += monitor_window_end[0];
            n[3] += monitor_window_end[1];
         end
         chk(n[0], j ? 30 : 20);
         chk(n[1], j ? 30 : 10);
         chk(n[2], j ? 30 : 10);
         chk(n[3], j ? 30 : 20);
      end
      $display("test windows done");
      // Monitor is out of reset and its window set before any output is selected.
      for (int i = 0; i < 6; i++)
      begin
         v = $urandom;
         v[24] = i[0];
         wr(`OFS_SELECT, v);
         rdc(`OFS_SELECT);
         m = model[3][24] ? 0 : model[3];
         repeat (3)
         begin
            @(posedge pclk);
            x = $urandom;
            y = $urandom;
            raw_out_sts <= x;
            raw_outb_sts <= y;
            @(posedge pclk);
            @(negedge pclk);
            chk({outb_mon_enable, out_mon_enable}, m[23:0]);
            chk({outb_sts, out_sts}, {y & m[23:12], x & m[11:0]});
         end
      end
      $display("test monitor select done");
      close_out;
   end
endmodule
